// File: rtl/flash_read_host.v
// Host controller for a serial flash: array reads and status-four write.
// Assumes a flash on cs/sck/io lines; software uses a strobe register port.
//
// Operation
// - C1h plus one byte, then raise select
// - Quad peripheral mode: nibbles, high first
// - 03h: opcode, 24-bit address, data falls
// - Host may raise select during data
// - 0Bh: address then one dummy byte
// - 3Bh: serial address, eight dummy, two lines
// - Host releases line zero before data
// - BBh: address, dummy, data two bits
// - 6Bh: serial address, eight dummy, four lines
// - Drive lines two, three high if needed; the code drives them only with hold pin enabled and protect pin not disabled
// - EBh: quad address, six dummy, nibbles
// - Complementary mode byte skips next opcode
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`include "flash_host_defs.vh"
module flash_read_host
(
  // Clock and reset
  input  wire       clk,
  input  wire       reset_n,
  // Software register port
  input  wire [3:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata_q,
  // Flash link
  output reg        cs_n_q,
  output reg        sck_out_q,
  output reg  [3:0] io_out_q,
  output reg  [3:0] io_oe_q,
  input  wire [3:0] io_in
);
  localparam ST_IDLE  = 3'h0;
  localparam ST_OP    = 3'h1;
  localparam ST_ADDR  = 3'h2;
  localparam ST_MODE  = 3'h3;
  localparam ST_DUMMY = 3'h4;
  localparam ST_DATA  = 3'h5;
  localparam ST_WDAT  = 3'h6;
  localparam ST_END   = 3'h7;

  reg  [2:0]  st_q;
  reg  [7:0]  ctrl_q;
  reg  [23:0] faddr_q;
  reg  [7:0]  wbyte_q;
  reg  [7:0]  mode_q;
  reg  [7:0]  rbyte_q;
  reg         rvalid_q;
  reg         cont_q;
  reg  [31:0] sh_q;
  reg  [5:0]  left_q;
  reg  [2:0]  width_q;
  reg  [3:0]  rcnt_q;
  reg  [7:0]  acc_q;
  reg         run_q;
  wire        sck;
  wire        rise;
  wire        fall;
  wire [3:0]  io_s;
  wire [2:0]  cmd;
  wire        quad_peripheral_mode;

  assign cmd = ctrl_q[2:0];
  assign quad_peripheral_mode = ctrl_q[`CTRL_QPI];

  sck_divider u_div
  (
    .clk     (clk),
    .reset_n (reset_n),
    .run     (run_q),
    .sck_q   (sck),
    .rise    (rise),
    .fall    (fall)
  );

  io_sync u_sync
  (
    .clk     (clk),
    .reset_n (reset_n),
    .raw     (io_in),
    .clean_q (io_s)
  );

  // Opcode for a command
  function [7:0] opcode;
    input [2:0] c;
    begin
      case (c)
        `CMD_READ:     opcode = `OP_READ;
        `CMD_FAST:     opcode = `OP_FAST_READ;
        `CMD_DUAL_OUT: opcode = `OP_DUAL_OUT_READ;
        `CMD_DUAL_IO:  opcode = `OP_DUAL_IO_READ;
        `CMD_QUAD_OUT: opcode = `OP_QUAD_OUT_READ;
        `CMD_QUAD_IO:  opcode = `OP_QUAD_IO_READ;
        default:       opcode = `OP_WRITE_STATUS_FOUR;
      endcase
    end
  endfunction

  // Bits per clock in the address phase
  function [2:0] addr_width;
    input [2:0] c;
    input       q;
    begin
      if (q || c == `CMD_QUAD_IO)
        addr_width = 3'h4;
      else if (c == `CMD_DUAL_IO)
        addr_width = 3'h2;
      else
        addr_width = 3'h1;
    end
  endfunction

  // Bits per clock in the data phase
  function [2:0] data_width;
    input [2:0] c;
    input       q;
    begin
      if (q || c == `CMD_QUAD_IO || c == `CMD_QUAD_OUT)
        data_width = 3'h4;
      else if (c == `CMD_DUAL_IO || c == `CMD_DUAL_OUT)
        data_width = 3'h2;
      else
        data_width = 3'h1;
    end
  endfunction

  // Dummy clock count per command
  function [5:0] dummy_clocks;
    input [2:0] c;
    begin
      case (c)
        `CMD_FAST:     dummy_clocks = `DUMMY_EIGHT;
        `CMD_DUAL_OUT: dummy_clocks = `DUMMY_EIGHT;
        `CMD_DUAL_IO:  dummy_clocks = `DUMMY_DUAL_IO;
        `CMD_QUAD_OUT: dummy_clocks = `DUMMY_EIGHT;
        `CMD_QUAD_IO:  dummy_clocks = `DUMMY_QUAD_IO;
        default:       dummy_clocks = 6'h00;
      endcase
    end
  endfunction

  // Clocks to shift n bits at width w
  function [5:0] clocks;
    input [5:0] n;
    input [2:0] w;
    begin
      if (w == 3'h4)
        clocks = {2'b00, n[5:2]};
      else if (w == 3'h2)
        clocks = {1'b0, n[5:1]};
      else
        clocks = n;
    end
  endfunction

  // Drive the top bits of word s, highest on highest line
  task drive;
    input [2:0]  w;
    input [31:0] s;
    begin
      if (w == 3'h4)
      begin
        io_out_q <= s[31:28];
        io_oe_q  <= 4'hf;
        sh_q     <= {s[27:0], 4'h0};
      end
      else if (w == 3'h2)
      begin
        io_out_q <= {io_out_q[3:2], s[31:30]};
        io_oe_q  <= {io_oe_q[3:2], 2'b11};
        sh_q     <= {s[29:0], 2'b00};
      end
      else
      begin
        io_out_q <= {io_out_q[3:1], s[31]};
        io_oe_q  <= {io_oe_q[3:1], 1'b1};
        sh_q     <= {s[30:0], 1'b0};
      end
    end
  endtask

  // Software register port
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      ctrl_q  <= 8'h00;
      faddr_q <= 24'h000000;
      wbyte_q <= 8'h00;
      mode_q  <= 8'h00;
      rdata_q <= 8'h00;
    end
    else
    begin
      if (wr && addr == `REG_CTRL)
        ctrl_q <= wdata;
      else
        ctrl_q <= {ctrl_q[7:5], 2'b00, ctrl_q[2:0]};
      if (wr && addr == `REG_ADDR)
        faddr_q <= {faddr_q[15:0], wdata};
      if (wr && addr == `REG_WDATA)
        wbyte_q <= wdata;
      if (wr && addr == `REG_MODE)
        mode_q <= wdata;
      if (rd)
      begin
        case (addr)
          `REG_CTRL:   rdata_q <= ctrl_q;
          `REG_ADDR:   rdata_q <= faddr_q[7:0];
          `REG_WDATA:  rdata_q <= wbyte_q;
          `REG_RDATA:  rdata_q <= rbyte_q;
          `REG_STATUS: rdata_q <= {5'h00, cont_q, rvalid_q,
                                   (st_q != ST_IDLE)};
          `REG_MODE:   rdata_q <= mode_q;
          default:     rdata_q <= 8'h00;
        endcase
      end
    end
  end

  // Link sequencer
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      st_q      <= ST_IDLE;
      cs_n_q    <= 1'b1;
      sck_out_q <= 1'b0;
      io_out_q  <= 4'h0;
      io_oe_q   <= 4'h0;
      sh_q      <= 32'h0;
      left_q    <= 6'h00;
      width_q   <= 3'h1;
      rcnt_q    <= 4'h0;
      acc_q     <= 8'h00;
      rbyte_q   <= 8'h00;
      rvalid_q  <= 1'b0;
      cont_q    <= 1'b0;
      run_q     <= 1'b0;
    end
    else
    begin
      // Pin clock follows the divider's next level, so data moves with it
      sck_out_q <= run_q && (sck ^ (rise || fall));
      if (rd && addr == `REG_RDATA && !(fall && st_q == ST_DATA))
        rvalid_q <= 1'b0;
      case (st_q)
        ST_IDLE:
        begin
          if (ctrl_q[`CTRL_START])
          begin
            cs_n_q <= 1'b0;
            run_q  <= 1'b1;
            rcnt_q <= 4'h0;
            acc_q  <= 8'h00;
            // Continuous mode goes straight to the address
            if (cont_q && cmd == `CMD_QUAD_IO)
            begin
              st_q    <= ST_ADDR;
              width_q <= 3'h4;
              left_q  <= clocks(`ADDR_BITS, 3'h4) - 6'h01;
              drive(3'h4, {faddr_q, 8'h00});
            end
            else
            begin
              st_q    <= ST_OP;
              width_q <= quad_peripheral_mode ? 3'h4 : 3'h1;
              sh_q    <= {opcode(cmd), 24'h0};
              left_q  <= clocks(6'h08, quad_peripheral_mode ? 3'h4 : 3'h1);
              // Hold and protect lines high through a quad output opcode and address
              if (cmd == `CMD_QUAD_OUT && !ctrl_q[`CTRL_PROTECT_PIN_DISABLE_BIT]
                  && ctrl_q[`CTRL_HOLD_PIN_ENABLE_BIT] && !quad_peripheral_mode)
              begin
                io_out_q <= 4'hc;
                io_oe_q  <= 4'hc;
              end
              else
              begin
                io_out_q <= 4'h0;
                io_oe_q  <= 4'h0;
              end
            end
          end
        end
        ST_OP, ST_ADDR, ST_MODE, ST_WDAT:
        begin
          if (fall || (st_q == ST_OP && left_q == clocks(6'h08, width_q)
                       && !sck && !rise))
          begin
            if (left_q == 6'h00)
            begin
              if (st_q == ST_OP && cmd == `CMD_WR_SR4)
              begin
                st_q   <= ST_WDAT;
                left_q <= clocks(6'h08, width_q) - 6'h01;
                drive(width_q, {wbyte_q, 24'h0});
              end
              else if (st_q == ST_OP)
              begin
                st_q    <= ST_ADDR;
                width_q <= addr_width(cmd, quad_peripheral_mode);
                left_q  <= clocks(`ADDR_BITS, addr_width(cmd, quad_peripheral_mode))
                           - 6'h01;
                drive(addr_width(cmd, quad_peripheral_mode), {faddr_q, 8'h00});
              end
              else if (st_q == ST_ADDR && cmd == `CMD_QUAD_IO)
              begin
                st_q   <= ST_MODE;
                left_q <= clocks(`MODE_BITS, 3'h4) - 6'h01;
                drive(3'h4, {mode_q, 24'h0});
              end
              else if (st_q == ST_WDAT)
              begin
                st_q  <= ST_END;
                run_q <= 1'b0;
              end
              else
              begin
                st_q    <= (dummy_clocks(cmd) == 6'h00) ? ST_DATA : ST_DUMMY;
                left_q  <= dummy_clocks(cmd);
                width_q <= data_width(cmd, quad_peripheral_mode);
                // Release lines so the flash may drive them
                io_oe_q <= 4'h0;
              end
            end
            else
            begin
              left_q <= left_q - 6'h01;
              drive(width_q, sh_q);
            end
          end
        end
        ST_DUMMY:
        begin
          if (fall)
          begin
            left_q <= left_q - 6'h01;
            if (left_q == 6'h01)
              st_q <= ST_DATA;
          end
        end
        ST_DATA:
        begin
          if (ctrl_q[`CTRL_STOP])
            st_q <= ST_END;
          else if (fall)
          begin
            // Sample one half clock late: the line sync needs four clocks
            if (width_q == 3'h4)
              acc_q <= {acc_q[3:0], io_s};
            else if (width_q == 3'h2)
              acc_q <= {acc_q[5:0], io_s[1:0]};
            else
              acc_q <= {acc_q[6:0], io_s[1]};
            if (rcnt_q + {1'b0, width_q} >= 4'h8)
            begin
              rcnt_q   <= 4'h0;
              rvalid_q <= 1'b1;
              if (width_q == 3'h4)
                rbyte_q <= {acc_q[3:0], io_s};
              else if (width_q == 3'h2)
                rbyte_q <= {acc_q[5:0], io_s[1:0]};
              else
                rbyte_q <= {acc_q[6:0], io_s[1]};
            end
            else
              rcnt_q <= rcnt_q + {1'b0, width_q};
          end
        end
        ST_END:
        begin
          // Stop the clock only in its low phase, never cut a high pulse
          if (fall || (!sck && !rise))
            run_q <= 1'b0;
          if (!run_q && !sck)
          begin
            cs_n_q  <= 1'b1;
            io_oe_q <= 4'h0;
            st_q    <= ST_IDLE;
            if (cmd == `CMD_QUAD_IO)
              cont_q <= (mode_q[7:4] == ~mode_q[3:0]);
          end
        end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end
endmodule

// File: rtl/flash_host_defs.vh
// Constants for the serial flash read and status-four host controller.
// Included by the host and divider design files; definitions only.
`ifndef FLASH_HOST_DEFS_VH
`define FLASH_HOST_DEFS_VH

// Opcodes
`define OP_WRITE_STATUS_FOUR 8'hc1
`define OP_READ              8'h03
`define OP_FAST_READ         8'h0b
`define OP_DUAL_OUT_READ     8'h3b
`define OP_DUAL_IO_READ      8'hbb
`define OP_QUAD_OUT_READ     8'h6b
`define OP_QUAD_IO_READ      8'heb

// Command codes in the control register
`define CMD_READ      3'h0
`define CMD_FAST      3'h1
`define CMD_DUAL_OUT  3'h2
`define CMD_DUAL_IO   3'h3
`define CMD_QUAD_OUT  3'h4
`define CMD_QUAD_IO   3'h5
`define CMD_WR_SR4    3'h6

// Software register offsets
`define REG_CTRL      4'h0
`define REG_ADDR      4'h1
`define REG_WDATA     4'h2
`define REG_RDATA     4'h3
`define REG_STATUS    4'h4
`define REG_MODE      4'h5

// Control register fields
`define CTRL_START    3
`define CTRL_STOP     4
`define CTRL_QPI      5
`define CTRL_PROTECT_PIN_DISABLE_BIT    6
`define CTRL_HOLD_PIN_ENABLE_BIT     7

// Status register fields
`define ST_BUSY       0
`define ST_RVALID     1
`define ST_CONT       2

// Status-four data bits
`define SR4_HOLD_EN   1
`define SR4_WP_DIS    2
`define SR4_CMP       6

// Link clock divider: half period in system clocks
`define SCK_HALF      4'h4

// Dummy clock counts and address and mode bit counts
`define DUMMY_EIGHT   6'h08
`define DUMMY_QUAD_IO 6'h06
`define DUMMY_DUAL_IO 6'h04
`define ADDR_BITS     6'h18
`define MODE_BITS     6'h08

`endif

// File: rtl/sck_divider.v
// Serial clock generator for the flash link.
// Assumes clk at 20 MHz; emits rise and fall pulses with the clock level.
`timescale 1ns/10ps
`include "flash_host_defs.vh"
module sck_divider
(
  // Clock and reset
  input  wire       clk,
  input  wire       reset_n,
  // Control
  input  wire       run,
  // Link clock
  output reg        sck_q,
  output wire       rise,
  output wire       fall
);
  reg  [3:0] cnt_q;
  wire       tick;

  assign tick = run && (cnt_q == `SCK_HALF - 4'h1);
  assign rise = tick && !sck_q;
  assign fall = tick && sck_q;

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      cnt_q <= 4'h0;
      sck_q <= 1'b0;
    end
    else if (!run)
    begin
      cnt_q <= 4'h0;
      sck_q <= 1'b0;
    end
    else if (tick)
    begin
      cnt_q <= 4'h0;
      sck_q <= !sck_q;
    end
    else
      cnt_q <= cnt_q + 4'h1;
  end
endmodule

// File: rtl/io_sync.v
// Three-stage synchroniser for the four data lines from the flash.
// Assumes lines are asynchronous to clk; a change counts once stage two
// and three agree.
`timescale 1ns/10ps
module io_sync
(
  // Clock and reset
  input  wire       clk,
  input  wire       reset_n,
  // Raw and filtered lines
  input  wire [3:0] raw,
  output reg  [3:0] clean_q
);
  reg [3:0] s1_q;
  reg [3:0] s2_q;
  reg [3:0] s3_q;
  genvar    i;

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      s3_q <= 4'h0;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  generate
    for (i = 0; i < 4; i = i + 1)
    begin : g_line
      always @(posedge clk)
      begin
        if (!reset_n)
          clean_q[i] <= 1'b0;
        else if (s2_q[i] == s3_q[i])
          clean_q[i] <= s3_q[i];
      end
    end
  endgenerate
endmodule

// File: bench/flash_read_host_props.sv
// Checker for the flash host link timing, bound to flash_read_host.
// Assumes the divider half period of four system clocks.
`timescale 1ns/10ps
module flash_read_host_props
(
  // Clock and reset
  input wire       clk,
  input wire       reset_n,
  // Software port
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire       wr,
  input wire       rd,
  input wire [7:0] rdata_q,
  // Flash link
  input wire       cs_n_q,
  input wire       sck_out_q,
  input wire [3:0] io_out_q,
  input wire [3:0] io_oe_q,
  input wire [3:0] io_in
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_sck_high;
    $rose(sck_out_q) |=> sck_out_q [*3] ##1 !sck_out_q;
  endproperty
  a_sck_high: assert property (p_sck_high)
    else $error("serial clock high phase wrong");
  property p_sck_low;
    $fell(sck_out_q) |=> !sck_out_q [*3];
  endproperty
  a_sck_low: assert property (p_sck_low)
    else $error("serial clock low phase short");
  property p_idle;
    cs_n_q |-> !sck_out_q;
  endproperty
  a_idle: assert property (p_idle)
    else $error("serial clock runs while deselected");
  property p_fall_cs;
    $fell(cs_n_q) |-> !sck_out_q ##1 !sck_out_q;
  endproperty
  a_fall_cs: assert property (p_fall_cs)
    else $error("clock high at select");
  property p_cs_rise;
    $rose(cs_n_q) |-> !sck_out_q && !$past(sck_out_q);
  endproperty
  a_cs_rise: assert property (p_cs_rise)
    else $error("select rose with clock high");
  property p_stable_io;
    !cs_n_q && sck_out_q && $past(sck_out_q)
      |-> $stable(io_out_q) && $stable(io_oe_q);
  endproperty
  a_stable_io: assert property (p_stable_io)
    else $error("lines moved while clock high");
  property p_release;
    cs_n_q && $past(cs_n_q) |-> io_oe_q == 4'h0;
  endproperty
  a_release: assert property (p_release)
    else $error("lines driven while deselected");
  sequence s_start;
    cs_n_q [*4] ##0 (wr && addr == 4'h0 && wdata[3]);
  endsequence
  property p_start;
    s_start |=> ##1 !cs_n_q;
  endproperty
  a_start: assert property (p_start)
    else $error("start did not select");
  c_quad: cover property (!cs_n_q && io_oe_q == 4'hf);
  c_dual: cover property (!cs_n_q && io_oe_q == 4'h3);
  c_end: cover property ($rose(cs_n_q));
endmodule

bind flash_read_host flash_read_host_props props_u (.clk(clk),
  .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata_q(rdata_q), .cs_n_q(cs_n_q), .sck_out_q(sck_out_q),
  .io_out_q(io_out_q), .io_oe_q(io_oe_q), .io_in(io_in));

// File: bench/flash_dev_model.sv
// Behavioural serial flash: reads, continuous quad mode, status four.
// Assumes mode 0 clocking; array byte is the xor of the address bytes.
`timescale 1ns/10ps
module flash_dev_model
(
  // Link from host
  input  wire       cs_n,
  input  wire       sck,
  input  wire [3:0] io,
  // Device drive
  output reg  [3:0] fo,
  output reg  [3:0] fe
);
  localparam LOCKED = 1'b0;
  reg [7:0]  sr4_q = 8'h00;
  reg [7:0]  pend_v = 8'h00;
  reg        pend_q = 1'b0;
  reg        cont_q = 1'b0;
  reg        wip_q = 1'b0;
  reg        chk = 1'b0;
  reg        q23_ok = 1'b1;
  reg [23:0] v;
  reg [23:0] a;
  reg [7:0]  op;
  reg [7:0]  b;
  integer    w;
  integer    i;
  initial fo = 4'h5;
  initial fe = 4'h0;
  function [7:0] mem(input [23:0] x);
    mem = x[7:0] ^ x[15:8] ^ x[23:16];
  endfunction
  task get(input integer gw, input integer n, output [23:0] r);
    integer k;
    begin
      r = 24'h000000;
      for (k = 0; k < n; k = k + 1)
      begin
        @(posedge sck);
        r = (r << gw) | (io & ((1 << gw) - 1));
        if (chk)
          q23_ok = q23_ok & (io[3:2] == 2'b11);
      end
    end
  endtask
  always @(negedge cs_n)
  begin : txn
    v = 24'h0000eb;
    if (!cont_q)
      get(1, 8, v);
    op = v[7:0];
    if (op == 8'hc1)
    begin
      get(1, 8, v);
      pend_v = v[7:0];
      pend_q = 1'b1;
    end
    else if (!wip_q)
    begin
      w = (op == 8'hbb) ? 2 : (op == 8'heb) ? 4 : 1;
      chk = (op == 8'h6b);
      q23_ok = q23_ok | chk;
      get(w, 24 / w, a);
      chk = 1'b0;
      if (op == 8'heb)
      begin
        get(4, 2, v);
        cont_q = v[7:4] == ~v[3:0];
        get(4, 6, v);
      end
      else if (op == 8'hbb)
        get(2, 4, v);
      else if (op != 8'h03)
        get(1, 8, v);
      w = (op == 8'h03 || op == 8'h0b) ? 1 :
          (op == 8'h3b || op == 8'hbb) ? 2 : 4;
      forever
      begin
        b = mem(a);
        for (i = 0; i < 8 / w; i = i + 1)
        begin
          @(negedge sck);
          fe = (w == 1) ? 4'h2 : (w == 2) ? 4'h3 : 4'hf;
          fo = (w == 1) ? {2'b00, b[7], 1'b0} :
               (w == 2) ? {2'b00, b[7:6]} : b[7:4];
          b = b << w;
        end
        a = a + 24'h000001;
      end
    end
  end
  // Select rise ends any transfer and commits a status-four write
  always @(posedge cs_n)
  begin
    disable txn;
    if (pend_q && !LOCKED)
    begin
      sr4_q = pend_v & 8'h46;
      wip_q = 1'b1;
    end
    pend_q = 1'b0;
    fe = 4'h0;
    fo = ~fo;
  end
  always @(posedge wip_q)
    #2000 wip_q = 1'b0;
endmodule

// File: bench/flash_read_host_bench.sv
// Self-checking bench for flash_read_host against the flash model.
// Assumes the register map of the host and a 20 MHz clock.
`timescale 1ns/10ps
`include "flash_host_defs.vh"
module flash_read_host_bench;
  reg        clk;
  reg        reset_n = 1'b0;
  reg        wr = 1'b0;
  reg        rd = 1'b0;
  reg  [3:0] addr = 4'h0;
  reg  [7:0] wdata = 8'h00;
  reg  [7:0] s;
  wire [7:0] rdata_q;
  wire       cs_n_q;
  wire       sck_out_q;
  wire [3:0] io_out_q;
  wire [3:0] io_oe_q;
  wire [3:0] io_in;
  wire [3:0] fo;
  wire [3:0] fe;
  integer    n_fail = 0;
  integer    samples_checked = 0;
  integer    n_clash = 0;
  integer    i;
  assign io_in = (io_oe_q & io_out_q) | (~io_oe_q & fo);
  flash_read_host dut_u (.clk(clk), .reset_n(reset_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q), .cs_n_q(cs_n_q),
    .sck_out_q(sck_out_q), .io_out_q(io_out_q), .io_oe_q(io_oe_q),
    .io_in(io_in));
  flash_dev_model dev_u (.cs_n(cs_n_q), .sck(sck_out_q), .io(io_in),
    .fo(fo), .fe(fe));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
    if ((fe & io_oe_q) != 4'h0)
      n_clash = n_clash + 1;
  task check(input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp)
      begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task final_report;
    begin
      if (n_fail == 0 && samples_checked > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task wr_reg(input [3:0] a, input [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rd_reg(input [3:0] a, output [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      d = rdata_q;
    end
  endtask
  task wait_st(input integer bt, input v);
    integer k;
    begin
      s[bt] = ~v;
      for (k = 0; k < 3000 && s[bt] !== v; k = k + 1)
        rd_reg(`REG_STATUS, s);
      check(s[bt], v);
    end
  endtask
  task rd_test(input [2:0] c, input [23:0] a, input integer n,
               input [7:0] hi);
    integer k;
    reg [23:0] x;
    reg [7:0] d;
    begin
      wr_reg(`REG_ADDR, a[23:16]);
      wr_reg(`REG_ADDR, a[15:8]);
      wr_reg(`REG_ADDR, a[7:0]);
      wr_reg(`REG_CTRL, hi | {5'h00, c} | 8'h08);
      for (k = 0; k < n; k = k + 1)
      begin
        x = a + k;
        wait_st(`ST_RVALID, 1'b1);
        rd_reg(`REG_RDATA, d);
        check(d, x[7:0] ^ x[15:8] ^ x[23:16]);
      end
      wr_reg(`REG_CTRL, hi | {5'h00, c} | 8'h10);
      wait_st(`ST_BUSY, 1'b0);
      rd_reg(`REG_RDATA, d);
    end
  endtask
  task t_regs;
    begin
      rd_reg(`REG_STATUS, s);
      check(s, 8'h00);
      rd_reg(4'hf, s);
      check(s, 8'h00);
    end
  endtask
  task t_reads;
    begin
      rd_test(`CMD_READ, 24'h012345, 3, 8'h00);
      rd_test(`CMD_FAST, 24'hfffffe, 3, 8'h00);
      rd_test(`CMD_DUAL_OUT, 24'h00a0f0, 2, 8'h00);
      rd_test(`CMD_DUAL_IO, 24'h3c5a01, 2, 8'h00);
      rd_test(`CMD_QUAD_OUT, 24'h7e0081, 2, 8'h80);
      check(dev_u.q23_ok, 1'b1);
      wr_reg(`REG_MODE, 8'hff);
      rd_test(`CMD_QUAD_IO, 24'hc0ffee, 2, 8'h00);
    end
  endtask
  task t_cont;
    reg [63:0] tbl;
    reg [7:0] m;
    begin
      tbl = 64'ha55af00fff00aa55;
      for (i = 0; i < 8; i = i + 1)
      begin
        m = tbl >> (56 - 8 * i);
        wr_reg(`REG_MODE, m);
        rd_test(`CMD_QUAD_IO, 24'h100000 + i * 3, 2, 8'h00);
        rd_reg(`REG_STATUS, s);
        check(s[`ST_CONT], m[7:4] == ~m[3:0]);
      end
      rd_test(`CMD_READ, 24'h000100, 1, 8'h00);
    end
  endtask
  task t_sr4;
    begin
      wr_reg(`REG_WDATA, 8'hff);
      wr_reg(`REG_CTRL, 8'h08 | {5'h00, `CMD_WR_SR4});
      wait_st(`ST_BUSY, 1'b0);
      repeat (4) @(posedge clk);
      check(dev_u.sr4_q, 8'h46);
      repeat (60) @(posedge clk);
    end
  endtask
  initial
  begin
    #3000000;
    n_fail = n_fail + 1;
    final_report;
  end
  initial
  begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    t_regs;
    t_sr4;
    t_reads;
    t_cont;
    check(n_clash, 0);
    final_report;
  end
endmodule
